// ### design/mmd_pkg.sv
package mmd_pkg;

  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned SPACE_BYTES  = 65536;
  localparam int unsigned IO_REGS      = 64;
  localparam int unsigned SYS_REGS     = 10;

  localparam logic [15:0] IO_LO        = 16'h0000;
  localparam logic [15:0] IO_HI        = 16'h003f;
  localparam logic [15:0] HIPAGE_LO    = 16'hfe00;
  localparam logic [15:0] HIPAGE_HI    = 16'hfe0f;
  localparam logic [15:0] COMPAT_LO    = 16'hfe10;
  localparam logic [15:0] COMPAT_HI    = 16'hfe1f;
  localparam logic [15:0] MON_LO       = 16'hfe20;
  localparam logic [15:0] MON_HI       = 16'hff55;
  localparam logic [15:0] VEC_LO       = 16'hffdc;
  localparam logic [15:0] VEC_HI       = 16'hffff;
  localparam logic [15:0] SEC_LO       = 16'hfff6;
  localparam logic [15:0] SEC_HI       = 16'hfffd;

  localparam int unsigned MON_BYTES    = 310;
  localparam int unsigned RAM_BYTES    = 512;
  localparam int unsigned FLASH_BYTES  = 16384;
  localparam int unsigned FLASH_USER   = 15872;
  localparam int unsigned BURN_BYTES   = 1024;
  localparam int unsigned VEC_BYTES    = 36;
  localparam int unsigned SEC_BYTES    = 8;

  localparam logic [15:0] RAM_BASE_DEF   = 16'h0040;
  localparam logic [15:0] FLASH_BASE_DEF = 16'hc000;
  localparam logic [15:0] BURN_BASE_DEF  = 16'h0800;

  // system register select order, high page then $FF7E and $FF80
  localparam int unsigned SYS_BRK_STAT   = 0;
  localparam int unsigned SYS_RST_STAT   = 1;
  localparam int unsigned SYS_BRK_FLAG   = 2;
  localparam int unsigned SYS_FLASH_CTL  = 3;
  localparam int unsigned SYS_BRK_ADDR_H = 4;
  localparam int unsigned SYS_BRK_ADDR_L = 5;
  localparam int unsigned SYS_BRK_CTL    = 6;
  localparam int unsigned SYS_LV_STAT    = 7;
  localparam int unsigned SYS_FLASH_PROT = 8;
  localparam int unsigned SYS_OSC_TRIM   = 9;

  localparam logic [15:0] SYS_ADDR [0:SYS_REGS-1] = '{
    16'hfe00, 16'hfe01, 16'hfe03, 16'hfe08, 16'hfe09,
    16'hfe0a, 16'hfe0b, 16'hfe0c, 16'hff7e, 16'hff80
  };

  typedef enum logic [8:0] {
    MMD_REG_IO    = 9'h001,
    MMD_REG_SYS   = 9'h002,
    MMD_REG_RAM   = 9'h004,
    MMD_REG_FLASH = 9'h008,
    MMD_REG_VEC   = 9'h010,
    MMD_REG_MON   = 9'h020,
    MMD_REG_BURN  = 9'h040,
    MMD_REG_RSVD  = 9'h080,
    MMD_REG_UNIMP = 9'h100
  } mmd_region_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } mmd_bus_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    mmd_region_t region;
    logic        flash_array;
    logic        secure;
    logic [2:0]  secure_idx;
  } mmd_decode_t;

endpackage : mmd_pkg

// ### design/mmd_rst_sync.sv
`timescale 1ns/1ps
module mmd_rst_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      rst_sync_n
);

  logic stage1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      stage1     <= 1'b1;
      rst_sync_n <= stage1;
    end
  end

endmodule : mmd_rst_sync

// ### design/mmd_decoder.sv
`timescale 1ns/1ps
// Function
// - every 16-bit address of the 64-Kbyte space resolves to one class
// - access to an unimplemented address raises an illegal-address reset request
// - $0000-$003F selects the peripheral control, status and data registers
// - system registers in the high page and at $FF7E/$FF80 selected individually, trim byte $FF80 optional
// - $FE10-$FE1F is a reserved compatibility block
// - monitor rom occupies 310 bytes, $FE20 to $FF55
// - a 512-byte read/write ram region is decoded
// - 16-Kbyte program array with 15,872 bytes of user space
// - a 1024-byte burn-in rom region is decoded
// - 36 vector bytes $FFDC-$FFFF belong to the program array
// - $FFF6-$FFFD flagged as the eight security bytes
module mmd_decoder #(
  parameter logic [15:0] RAM_BASE   = mmd_pkg::RAM_BASE_DEF,
  parameter logic [15:0] FLASH_BASE = mmd_pkg::FLASH_BASE_DEF,
  parameter logic [15:0] BURN_BASE  = mmd_pkg::BURN_BASE_DEF,
  parameter bit          TRIM_EN    = 1'b1
) (
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  input  wire mmd_pkg::mmd_bus_t                     bus,
  output mmd_pkg::mmd_decode_t                       dec,
  output logic [mmd_pkg::IO_REGS-1:0]                io_sel,
  output logic [mmd_pkg::SYS_REGS-1:0]               sys_sel,
  output logic                                       illegal_req,
  output logic [mmd_pkg::ADDR_W-1:0]                 illegal_addr,
  output logic                                       rsvd_hit
);

  localparam logic [15:0] RAM_HI   = 16'(32'(RAM_BASE) + mmd_pkg::RAM_BYTES - 1);
  localparam logic [15:0] FLASH_HI = 16'(32'(FLASH_BASE) + mmd_pkg::FLASH_USER - 1);
  localparam logic [15:0] BURN_HI  = 16'(32'(BURN_BASE) + mmd_pkg::BURN_BYTES - 1);

  // ram and burn-in must fit the space above the i/o registers, program array must end below the high page, burn-in must miss ram and program array
  if (32'(RAM_BASE) + mmd_pkg::RAM_BYTES > mmd_pkg::SPACE_BYTES ||
      RAM_BASE <= mmd_pkg::IO_HI) begin : g_bad_ram
    $error("ram region placement not servable");
  end
  if (32'(FLASH_BASE) + mmd_pkg::FLASH_USER > 32'(mmd_pkg::HIPAGE_LO)) begin : g_bad_flash
    $error("program array runs into the high page");
  end
  if (32'(BURN_BASE) + mmd_pkg::BURN_BYTES > mmd_pkg::SPACE_BYTES ||
      BURN_BASE <= mmd_pkg::IO_HI ||
      (BURN_BASE <= RAM_HI && BURN_HI >= RAM_BASE) ||
      (BURN_BASE <= FLASH_HI && BURN_HI >= FLASH_BASE)) begin : g_bad_burn
    $error("burn-in rom overlaps another region");
  end

  logic rst_sync_n;

  mmd_rst_sync u_rst_sync (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .rst_sync_n (rst_sync_n)
  );

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic is_sys(input logic [15:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < mmd_pkg::SYS_REGS; i++) begin
      if (a == mmd_pkg::SYS_ADDR[i] && (i != mmd_pkg::SYS_OSC_TRIM || TRIM_EN)) begin
        hit = 1'b1;
      end
    end
    is_sys = hit;
  endfunction : is_sys

  function automatic mmd_pkg::mmd_region_t region_of(input logic [15:0] a);
    mmd_pkg::mmd_region_t r;
    r = mmd_pkg::MMD_REG_UNIMP;
    if (in_range(a, mmd_pkg::IO_LO, mmd_pkg::IO_HI)) begin
      r = mmd_pkg::MMD_REG_IO;
    end else if (is_sys(a)) begin
      r = mmd_pkg::MMD_REG_SYS;
    end else if (in_range(a, mmd_pkg::HIPAGE_LO, mmd_pkg::HIPAGE_HI)) begin
      r = mmd_pkg::MMD_REG_RSVD;
    end else if (in_range(a, mmd_pkg::COMPAT_LO, mmd_pkg::COMPAT_HI)) begin
      r = mmd_pkg::MMD_REG_RSVD;
    end else if (in_range(a, mmd_pkg::MON_LO, mmd_pkg::MON_HI)) begin
      r = mmd_pkg::MMD_REG_MON;
    end else if (in_range(a, RAM_BASE, RAM_HI)) begin
      r = mmd_pkg::MMD_REG_RAM;
    end else if (in_range(a, FLASH_BASE, FLASH_HI)) begin
      r = mmd_pkg::MMD_REG_FLASH;
    end else if (in_range(a, BURN_BASE, BURN_HI)) begin
      r = mmd_pkg::MMD_REG_BURN;
    end else if (in_range(a, mmd_pkg::VEC_LO, mmd_pkg::VEC_HI)) begin
      r = mmd_pkg::MMD_REG_VEC;
    end
    region_of = r;
  endfunction : region_of

  mmd_pkg::mmd_region_t        next_region;
  logic [mmd_pkg::IO_REGS-1:0]  next_io_sel;
  logic [mmd_pkg::SYS_REGS-1:0] next_sys_sel;
  logic                         next_secure;

  always_comb begin
    next_region = region_of(bus.addr);
    next_secure = in_range(bus.addr, mmd_pkg::SEC_LO, mmd_pkg::SEC_HI);
  end

  for (genvar gi = 0; gi < mmd_pkg::IO_REGS; gi++) begin : g_io
    assign next_io_sel[gi] = bus.valid && (bus.addr == 16'(32'(mmd_pkg::IO_LO) + gi));
  end

  for (genvar gs = 0; gs < mmd_pkg::SYS_REGS; gs++) begin : g_sys
    if (gs == mmd_pkg::SYS_OSC_TRIM && !TRIM_EN) begin : g_off
      assign next_sys_sel[gs] = 1'b0;
    end else begin : g_on
      assign next_sys_sel[gs] = bus.valid && (bus.addr == mmd_pkg::SYS_ADDR[gs]);
    end
  end

  // decode registered on the address edge, one cycle ahead of the data phase
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dec.valid       <= 1'b0;
      dec.write       <= 1'b0;
      dec.region      <= mmd_pkg::MMD_REG_UNIMP;
      dec.flash_array <= 1'b0;
      dec.secure      <= 1'b0;
      dec.secure_idx  <= 3'h0;
    end else begin
      dec.valid       <= bus.valid;
      dec.write       <= bus.write;
      dec.region      <= next_region;
      dec.flash_array <= bus.valid && (next_region == mmd_pkg::MMD_REG_FLASH ||
                                       next_region == mmd_pkg::MMD_REG_VEC);
      dec.secure      <= bus.valid && next_secure;
      dec.secure_idx  <= next_secure ? 3'(bus.addr - mmd_pkg::SEC_LO) : 3'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      io_sel  <= '0;
      sys_sel <= '0;
    end else begin
      io_sel  <= next_io_sel;
      sys_sel <= next_sys_sel;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      illegal_req  <= 1'b0;
      illegal_addr <= 16'h0000;
    end else begin
      illegal_req <= bus.valid && (next_region == mmd_pkg::MMD_REG_UNIMP);
      if (bus.valid && next_region == mmd_pkg::MMD_REG_UNIMP) begin
        illegal_addr <= bus.addr;
      end
    end
  end

  // reserved hits are only reported; nothing is guarded against them
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rsvd_hit <= 1'b0;
    end else begin
      rsvd_hit <= bus.valid && (next_region == mmd_pkg::MMD_REG_RSVD);
    end
  end

endmodule : mmd_decoder

// ### test/mmd_decoder_properties.sv
`timescale 1ns/1ps
module mmd_decoder_properties (
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire mmd_pkg::mmd_bus_t          bus,
  input wire mmd_pkg::mmd_decode_t       dec,
  input wire logic [mmd_pkg::IO_REGS-1:0]  io_sel,
  input wire logic [mmd_pkg::SYS_REGS-1:0] sys_sel,
  input wire logic                       illegal_req,
  input wire logic [mmd_pkg::ADDR_W-1:0]   illegal_addr,
  input wire logic                       rsvd_hit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_IO_SEL: assert property (bus.valid && bus.addr <= 16'h003f
    |=> io_sel == (64'h1 << $past(bus.addr[5:0]))) else $error("io select wrong");
  AST_SYS_SEL: assert property (bus.valid && bus.addr == 16'hfe0c |=> sys_sel == 10'h080)
    else $error("system select wrong");
  AST_ILLEGAL: assert property (illegal_req |-> $past(bus.valid) && dec.region == mmd_pkg::MMD_REG_UNIMP)
    else $error("illegal pulse without cause");
  AST_ILL_ADDR: assert property (illegal_req |-> illegal_addr == $past(bus.addr))
    else $error("illegal address wrong");
  AST_RSVD: assert property (bus.valid && bus.addr inside {[16'hfe10:16'hfe1f]}
    |=> rsvd_hit && !illegal_req) else $error("reserved block missed");
  AST_SEC: assert property (bus.valid && bus.addr inside {[16'hfff6:16'hfffd]}
    |=> dec.secure && dec.secure_idx == $past(bus.addr[2:0]) - 3'h6) else $error("security byte wrong");
  AST_VEC: assert property (bus.valid && bus.addr >= 16'hffdc
    |=> dec.flash_array && dec.region == mmd_pkg::MMD_REG_VEC) else $error("vector decode wrong");
  AST_IDLE: assert property (!bus.valid |=> !dec.valid && !illegal_req && io_sel == '0 && sys_sel == '0)
    else $error("output on idle cycle");
endmodule : mmd_decoder_properties
bind mmd_decoder mmd_decoder_properties i_mmd_decoder_properties (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
  .dec(dec), .io_sel(io_sel), .sys_sel(sys_sel), .illegal_req(illegal_req), .illegal_addr(illegal_addr),
  .rsvd_hit(rsvd_hit));

// ### test/mmd_cpu_model.sv
`timescale 1ns/1ps
module mmd_cpu_model (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire mmd_pkg::mmd_bus_t req,
  output mmd_pkg::mmd_bus_t      bus
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus <= '0;
    end else if (req.valid) begin
      bus <= req; // one commanded access a cycle
    end else begin
      bus <= '{valid: 1'b0, write: ~bus.write, addr: ~bus.addr};
    end
  end
endmodule : mmd_cpu_model

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    mmd_pkg::mmd_region_t region;
    logic                 write;
    logic [63:0]          io;
    logic [9:0]           sys;
    logic                 flash;
    logic                 secure;
    logic [2:0]           idx;
    logic [15:0]          addr;
  } mmd_exp_t;
  logic                 clk_sys = 1'b0;
  logic                 rst_n   = 1'b0;
  mmd_pkg::mmd_bus_t    req     = '0;
  mmd_pkg::mmd_bus_t    bus;
  mmd_pkg::mmd_decode_t dec;
  logic [63:0]          io_sel;
  logic [9:0]           sys_sel;
  logic                 illegal_req;
  logic [15:0]          illegal_addr;
  logic                 rsvd_hit;
  mmd_exp_t             q[$];
  mmd_exp_t             e;
  int                   n_mismatch = 0;
  int                   compares   = 0;
  localparam logic [15:0] DIR [32] = '{16'h0000, 16'h003f, 16'h0040, 16'h023f, 16'h0240, 16'h0800, 16'h0bff,
    16'h0c00, 16'hbfff, 16'hc000, 16'hfdff, 16'hfe00, 16'hfe01, 16'hfe02, 16'hfe03, 16'hfe08, 16'hfe0c, 16'hfe0d,
    16'hfe10, 16'hfe1f, 16'hfe20, 16'hff55, 16'hff56, 16'hff7e, 16'hff7f, 16'hff80, 16'hffdb, 16'hffdc, 16'hfff6,
    16'hfffa, 16'hfffd, 16'hffff};
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  mmd_cpu_model i_mmd_cpu_model (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .bus(bus));
  mmd_decoder i_mmd_decoder (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .dec(dec), .io_sel(io_sel),
    .sys_sel(sys_sel), .illegal_req(illegal_req), .illegal_addr(illegal_addr), .rsvd_hit(rsvd_hit));
  function automatic mmd_exp_t expect_of(logic [15:0] a, logic w);
    mmd_exp_t x;
    x = '{region: mmd_pkg::MMD_REG_UNIMP, write: w, io: '0, sys: '0, flash: 1'b0, secure: 1'b0, idx: 3'h0, addr: a};
    for (int i = 0; i < 10; i++) begin
      if (a == mmd_pkg::SYS_ADDR[i]) x.sys[i] = 1'b1;
    end
    if (a <= 16'h003f) x.region = mmd_pkg::MMD_REG_IO;
    else if (a inside {[16'h0040:16'h023f]}) x.region = mmd_pkg::MMD_REG_RAM;
    else if (a inside {[16'h0800:16'h0bff]}) x.region = mmd_pkg::MMD_REG_BURN;
    else if (a inside {[16'hc000:16'hfdff]}) x.region = mmd_pkg::MMD_REG_FLASH;
    else if (x.sys != '0) x.region = mmd_pkg::MMD_REG_SYS;
    else if (a inside {16'hfe02, [16'hfe04:16'hfe07], [16'hfe0d:16'hfe1f]}) x.region = mmd_pkg::MMD_REG_RSVD;
    else if (a inside {[16'hfe20:16'hff55]}) x.region = mmd_pkg::MMD_REG_MON;
    else if (a >= 16'hffdc) x.region = mmd_pkg::MMD_REG_VEC;
    if (a <= 16'h003f) x.io = 64'h1 << a[5:0];
    x.flash = x.region inside {mmd_pkg::MMD_REG_FLASH, mmd_pkg::MMD_REG_VEC};
    x.secure = a inside {[16'hfff6:16'hfffd]};
    if (x.secure) x.idx = 3'(a - 16'hfff6);
    return x;
  endfunction : expect_of
  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic send(logic [15:0] a, logic w);
    @(posedge clk_sys);
    req <= '{valid: 1'b1, write: w, addr: a};
    q.push_back(expect_of(a, w));
  endtask : send
  task automatic drain(string name);
    @(posedge clk_sys);
    req <= '0;
    for (int i = 0; i < 10 && q.size() != 0; i++) @(posedge clk_sys);
    if (q.size() != 0) begin
      n_mismatch++;
      $display("unexpected %0t no decode answer", $time);
      finish_test();
    end else begin
      $display("test %s done", name);
    end
  endtask : drain
  always @(posedge clk_sys) begin
    #1;
    if (dec.valid === 1'b1) begin
      e = q.size() != 0 ? q.pop_front() : '0;
      compares++;
      if (dec.region !== e.region || dec.write !== e.write ||
          illegal_req !== (e.region == mmd_pkg::MMD_REG_UNIMP) ||
          (illegal_req && illegal_addr !== e.addr)) begin
        n_mismatch++;
        $display("unexpected %0t decode of %h", $time, e.addr);
      end
      if (io_sel !== e.io || sys_sel !== e.sys) begin
        n_mismatch++;
        $display("unexpected %0t select of %h", $time, e.addr);
      end
      if (rsvd_hit !== (e.region == mmd_pkg::MMD_REG_RSVD)) begin
        n_mismatch++;
        $display("unexpected %0t reserved flag of %h", $time, e.addr);
      end
      if (dec.flash_array !== e.flash || dec.secure !== e.secure || dec.secure_idx !== e.idx) begin
        n_mismatch++;
        $display("unexpected %0t array or security of %h", $time, e.addr);
      end
    end
  end
  initial begin
    void'($urandom(32'hd97c7432));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (DIR[i]) send(DIR[i], 1'(i)); // boundaries of every region
    drain("directed");
    repeat (400) begin
      if ($urandom % 4 == 0) begin
        @(posedge clk_sys);
        req <= '0;
      end
      send($urandom % 2 ? 16'(16'hfe00 + $urandom % 512) : 16'($urandom), 1'($urandom));
    end
    drain("random");
    finish_test();
  end
endmodule : tb
